/* File: hw/sdic_ctrl.v */
// sdram init, self-refresh and command sequencer with register port
// Behaviour
// - init: precharge-all, eight refreshes, mode set
// - hold cpu while a command runs
// - init clears command field on completion
// - bank bits placed by mux type and sdram density
// - mux type code selects type a, b, c
// - code 0x04 issues a mode register set
// - code 101 enters self-refresh
// - code 110 exits, refreshes once, clears field
// - periodic auto-refresh at selected interval
//
// The placing of the registers and the plain strobed port were decided locally.
`default_nettype none
`include "sdic_regs.vh"
module sdic_ctrl #(
  parameter CLK_HALF = 2, // system cycles per half memory clock
  parameter GAP_STEPS = 4 // nop memory clocks after each sequencer command
) (
  input wire clk_sys, // system clock, 250 mhz
  input wire rstn, // async reset, active low
  input wire [3:0] reg_addr, // register index
  input wire [7:0] reg_wdata, // write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [7:0] reg_rdata, // read data, cycle after strobe
  input wire acc_valid, // access engine has a command
  input wire acc_ras_n, // access row strobe, low active
  input wire acc_cas_n, // access column strobe, low active
  input wire acc_we_n, // access write enable, low active
  input wire [14:0] acc_addr, // access row or column address
  input wire [1:0] acc_bank, // access bank
  input wire [1:0] acc_dqm, // access byte masks, upper then lower
  output reg acc_ready, // access may be taken on next step
  output reg cpu_hold, // stall cpu fetch and execution
  output reg mem_clock_out, // sdram clock
  output reg clock_enable_out, // sdram clock enable
  output reg mem_chip_select_out_n, // sdram chip select, low
  output reg row_strobe_out_n, // sdram ras, low
  output reg column_strobe_out_n, // sdram cas, low
  output reg write_enable_out_n, // sdram we, low
  output reg upper_byte_mask_out, // upper byte mask
  output reg lower_byte_mask_out, // lower byte mask
  output reg [15:0] mem_addr_out // sdram address a0..a15
);
  // sequencer states
  localparam S_IDLE = 3'h0;
  localparam S_GAP = 3'h1;
  localparam S_REFS = 3'h2;
  localparam S_MRS = 3'h3;
  localparam S_AREF1 = 3'h4;
  localparam S_FIN = 3'h5;

  reg [2:0] command_code_field; // running command, zero when idle
  reg [7:0] refresh_control_reg; // enable and interval select
  reg [7:0] burst_access_config; // mux type and density flag
  reg [7:0] mode_value; // mode register value sent by mrs
  reg in_self; // sdram is in self-refresh
  reg [2:0] state; // sequencer state
  reg [2:0] after_gap; // state entered when gap ends
  reg [3:0] ref_left; // init refreshes still to issue
  reg [3:0] gap_cnt; // nop steps remaining
  reg [3:0] div_cnt; // memory clock divider
  reg ar_active; // running command is a periodic refresh
  reg ref_ack; // one-cycle ack to the refresh timer
  wire ref_due; // periodic refresh owed
  wire tick; // half memory clock elapsed
  wire step; // falling edge of memory clock: pins change
  wire write_ok; // command write is accepted

  assign tick = (div_cnt == CLK_HALF[3:0] - 4'h1);
  assign step = tick & mem_clock_out;

  // place address and bank bits on the pins by mux type and density
  function [15:0] sdic_place;
    input [14:0] a;
    input [1:0] bank;
    input [7:0] acr;
    reg [15:0] r;
    begin
      r = {1'b0, a};
      case (acr[`SDIC_ACR_MUX_HI:`SDIC_ACR_MUX_LO])
        `SDIC_MUX_A:
          if (acr[`SDIC_ACR_SMALL])
            r[11] = bank[0];
          else
            r[13:12] = bank;
        `SDIC_MUX_B:
          if (acr[`SDIC_ACR_SMALL])
            r[13:12] = bank;
          else
            r[14:13] = bank;
        default:
          r[14:13] = bank;
      endcase
      sdic_place = r;
    end
  endfunction

  // commands legal now: init, mrs and self-refresh entry only out of self-refresh, exit only in it;
  // a write during a periodic refresh waits in the field until it ends
  assign write_ok = reg_wr && (reg_addr == `SDIC_OFS_CMD) &&
    (command_code_field == `SDIC_CMD_NONE) &&
    (((reg_wdata[2:0] == `SDIC_CMD_INIT ||
       reg_wdata[2:0] == `SDIC_CMD_MRS ||
       reg_wdata[2:0] == `SDIC_CMD_SRE) && !in_self) ||
     (reg_wdata[2:0] == `SDIC_CMD_SRX && in_self));

  // ============================================================
  // periodic refresh timer, idle while in self-refresh
  sdic_refresh_timer u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .enable(refresh_control_reg[`SDIC_RCR_EN] & ~in_self),
    .sel(refresh_control_reg[`SDIC_RCR_SEL_HI:`SDIC_RCR_SEL_LO]),
    .ack(ref_ack),
    .due(ref_due)
  );

  // ============================================================
  // memory clock divider
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      div_cnt <= 4'h0;
      mem_clock_out <= 1'b0;
    end
    else if (tick)
    begin
      div_cnt <= 4'h0;
      mem_clock_out <= ~mem_clock_out;
    end
    else
      div_cnt <= div_cnt + 4'h1;
  end

  // ============================================================
  // configuration registers
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      refresh_control_reg <= `SDIC_RST_RCR;
      burst_access_config <= `SDIC_RST_ACR;
      mode_value <= `SDIC_RST_MODE;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `SDIC_OFS_RCR: refresh_control_reg <= {4'h0, reg_wdata[3:0]};
        `SDIC_OFS_ACR: burst_access_config <= {5'h00, reg_wdata[2:0]};
        `SDIC_OFS_MODE: mode_value <= reg_wdata;
        default: ;
      endcase
    end
  end

  // ============================================================
  // read port: data in the cycle after the strobe, zero elsewhere
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `SDIC_OFS_CMD: reg_rdata <= {5'h00, command_code_field};
        `SDIC_OFS_RCR: reg_rdata <= refresh_control_reg;
        `SDIC_OFS_ACR: reg_rdata <= burst_access_config;
        `SDIC_OFS_MODE: reg_rdata <= mode_value;
        `SDIC_OFS_STAT: reg_rdata <= {5'h00, ref_due, in_self, cpu_hold};
        default: reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // ============================================================
  // command sequencer and sdram pins
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      command_code_field <= `SDIC_CMD_NONE;
      state <= S_IDLE;
      after_gap <= S_IDLE;
      ref_left <= 4'h0;
      gap_cnt <= 4'h0;
      in_self <= 1'b0;
      ar_active <= 1'b0;
      ref_ack <= 1'b0;
      cpu_hold <= 1'b0;
      acc_ready <= 1'b0;
      clock_enable_out <= 1'b1;
      mem_chip_select_out_n <= 1'b1;
      row_strobe_out_n <= 1'b1;
      column_strobe_out_n <= 1'b1;
      write_enable_out_n <= 1'b1;
      upper_byte_mask_out <= 1'b1;
      lower_byte_mask_out <= 1'b1;
      mem_addr_out <= 16'h0000;
    end
    else
    begin
      ref_ack <= 1'b0;
      // stall from the accepted write onward
      if (write_ok)
      begin
        command_code_field <= reg_wdata[2:0];
        cpu_hold <= 1'b1;
      end
      acc_ready <= (state == S_IDLE) && !write_ok && !cpu_hold &&
        (command_code_field == `SDIC_CMD_NONE) && !ref_due && !in_self;
      if (step)
      begin
        // default on each step: deselect, nop
        mem_chip_select_out_n <= 1'b1;
        row_strobe_out_n <= 1'b1;
        column_strobe_out_n <= 1'b1;
        write_enable_out_n <= 1'b1;
        case (state)
          S_IDLE:
            case (command_code_field)
              `SDIC_CMD_INIT:
              begin
                mem_chip_select_out_n <= 1'b0;
                row_strobe_out_n <= 1'b0;
                write_enable_out_n <= 1'b0;
                mem_addr_out <= 16'h0400;
                ref_left <= `SDIC_INIT_REFS;
                after_gap <= S_REFS;
                gap_cnt <= GAP_STEPS[3:0];
                state <= S_GAP;
              end
              // mode register set on code 0x04
              `SDIC_CMD_MRS:
              begin
                state <= S_MRS;
              end
              // self-refresh entry: refresh with cke low
              `SDIC_CMD_SRE:
              begin
                mem_chip_select_out_n <= 1'b0;
                row_strobe_out_n <= 1'b0;
                column_strobe_out_n <= 1'b0;
                clock_enable_out <= 1'b0;
                in_self <= 1'b1;
                after_gap <= S_FIN;
                gap_cnt <= GAP_STEPS[3:0];
                state <= S_GAP;
              end
              // exit: raise cke, then one refresh
              `SDIC_CMD_SRX:
              begin
                clock_enable_out <= 1'b1;
                in_self <= 1'b0;
                after_gap <= S_AREF1;
                gap_cnt <= GAP_STEPS[3:0];
                state <= S_GAP;
              end
              default:
                // periodic refresh has priority over access
                if (ref_due && !in_self)
                begin
                  mem_chip_select_out_n <= 1'b0;
                  row_strobe_out_n <= 1'b0;
                  column_strobe_out_n <= 1'b0;
                  ref_ack <= 1'b1;
                  cpu_hold <= 1'b1;
                  ar_active <= 1'b1;
                  after_gap <= S_FIN;
                  gap_cnt <= GAP_STEPS[3:0];
                  state <= S_GAP;
                end
                else if (acc_valid && acc_ready)
                begin
                  mem_chip_select_out_n <= 1'b0;
                  row_strobe_out_n <= acc_ras_n;
                  column_strobe_out_n <= acc_cas_n;
                  write_enable_out_n <= acc_we_n;
                  upper_byte_mask_out <= acc_dqm[1];
                  lower_byte_mask_out <= acc_dqm[0];
                  mem_addr_out <= sdic_place(acc_addr, acc_bank,
                    burst_access_config);
                end
            endcase
          S_GAP:
            if (gap_cnt <= 4'h1)
              state <= after_gap;
            else
              gap_cnt <= gap_cnt - 4'h1;
          S_REFS:
          begin
            mem_chip_select_out_n <= 1'b0;
            row_strobe_out_n <= 1'b0;
            column_strobe_out_n <= 1'b0;
            ref_left <= ref_left - 4'h1;
            after_gap <= (ref_left == 4'h1) ? S_MRS : S_REFS;
            gap_cnt <= GAP_STEPS[3:0];
            state <= S_GAP;
          end
          // mode register set closes the sequence
          S_MRS:
          begin
            mem_chip_select_out_n <= 1'b0;
            row_strobe_out_n <= 1'b0;
            column_strobe_out_n <= 1'b0;
            write_enable_out_n <= 1'b0;
            // bank bits zero, placed per mux type
            mem_addr_out <= sdic_place({7'h00, mode_value}, 2'h0,
              burst_access_config);
            after_gap <= S_FIN;
            gap_cnt <= GAP_STEPS[3:0];
            state <= S_GAP;
          end
          S_AREF1:
          begin
            mem_chip_select_out_n <= 1'b0;
            row_strobe_out_n <= 1'b0;
            column_strobe_out_n <= 1'b0;
            after_gap <= S_FIN;
            gap_cnt <= GAP_STEPS[3:0];
            state <= S_GAP;
          end
          S_FIN:
          begin
            // a command taken during a periodic refresh stays pending
            if (!ar_active)
              command_code_field <= `SDIC_CMD_NONE;
            if (!ar_active ||
              (command_code_field == `SDIC_CMD_NONE && !write_ok))
              cpu_hold <= 1'b0;
            ar_active <= 1'b0;
            state <= S_IDLE;
          end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end
endmodule // sdic_ctrl
`default_nettype wire

/* File: hw/sdic_refresh_timer.v */
// auto-refresh interval timer for the sdram command controller
`default_nettype none
`include "sdic_regs.vh"
module sdic_refresh_timer (
  input wire clk_sys, // system clock
  input wire rstn, // async reset, active low
  input wire enable, // periodic refresh enabled
  input wire [2:0] sel, // interval select
  input wire ack, // one-cycle: a refresh was issued
  output reg due // level: a refresh is owed
);
  reg [8:0] count; // states since due was last raised

  // interval in system-clock states for each select code
  function [8:0] sdic_interval;
    input [2:0] s;
    begin
      case (s)
        3'h0: sdic_interval = `SDIC_IVL_0;
        3'h1: sdic_interval = `SDIC_IVL_1;
        3'h2: sdic_interval = `SDIC_IVL_2;
        3'h3: sdic_interval = `SDIC_IVL_3;
        3'h4: sdic_interval = `SDIC_IVL_4;
        3'h5: sdic_interval = `SDIC_IVL_5;
        3'h6: sdic_interval = `SDIC_IVL_6;
        default: sdic_interval = `SDIC_IVL_7;
      endcase
    end
  endfunction

  // ============================================================
  // interval counter; due set wins over ack in the same cycle
  always @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= 9'h000;
      due <= 1'b0;
    end
    else if (!enable)
    begin
      count <= 9'h000;
      due <= 1'b0;
    end
    else
    begin
      if (count >= sdic_interval(sel) - 9'h001)
      begin
        count <= 9'h000;
        due <= 1'b1;
      end
      else
      begin
        count <= count + 9'h001;
        if (ack)
          due <= 1'b0;
      end
    end
  end
endmodule // sdic_refresh_timer
`default_nettype wire

/* File: hw/sdic_regs.vh */
// register offsets, field layout, command codes and timing for sdic
`ifndef SDIC_REGS_VH
`define SDIC_REGS_VH
// ============================================================
// register indices on the plain register port
`define SDIC_OFS_CMD 4'h0
`define SDIC_OFS_RCR 4'h1
`define SDIC_OFS_ACR 4'h2
`define SDIC_OFS_MODE 4'h3
`define SDIC_OFS_STAT 4'h4
// ============================================================
// command_code_field values
`define SDIC_CMD_NONE 3'h0
`define SDIC_CMD_INIT 3'h1
`define SDIC_CMD_MRS 3'h4
`define SDIC_CMD_SRE 3'h5
`define SDIC_CMD_SRX 3'h6
// ============================================================
// refresh_control_reg fields
`define SDIC_RCR_EN 0
`define SDIC_RCR_SEL_LO 1
`define SDIC_RCR_SEL_HI 3
// burst_access_config fields: mux type and lower-density flag
`define SDIC_ACR_MUX_LO 0
`define SDIC_ACR_MUX_HI 1
`define SDIC_ACR_SMALL 2
`define SDIC_MUX_A 2'h0
`define SDIC_MUX_B 2'h1
`define SDIC_MUX_C 2'h2
// ============================================================
// reset values
`define SDIC_RST_RCR 8'h00
`define SDIC_RST_ACR 8'h00
`define SDIC_RST_MODE 8'h00
// ============================================================
// timing: refreshes in the power-up sequence, interval table in states
`define SDIC_INIT_REFS 4'h8
`define SDIC_IVL_0 9'h02F
`define SDIC_IVL_1 9'h04E
`define SDIC_IVL_2 9'h061
`define SDIC_IVL_3 9'h07C
`define SDIC_IVL_4 9'h09C
`define SDIC_IVL_5 9'h0C3
`define SDIC_IVL_6 9'h0F9
`define SDIC_IVL_7 9'h138
`endif

/* File: verif/sdic_ctrl_asserts.sv */
// port checker for the sdram command controller
`default_nettype none
module sdic_ctrl_asserts #(
  parameter CLK_HALF = 2 // cycles per half memory clock
) (
  input wire logic clk_sys, // system clock
  input wire logic rstn, // reset, low
  input wire logic [3:0] reg_addr, // index
  input wire logic reg_rd, // read strobe
  input wire logic [7:0] reg_rdata, // read data
  input wire logic acc_ready, // access may go
  input wire logic cpu_hold, // cpu stall
  input wire logic mem_clock_out, // sdram clock
  input wire logic clock_enable_out, // cke
  input wire logic mem_chip_select_out_n, // cs
  input wire logic row_strobe_out_n, // ras
  input wire logic column_strobe_out_n, // cas
  input wire logic write_enable_out_n, // we
  input wire logic [15:0] mem_addr_out // address
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cmd; // cs ras cas we
  logic pre_all, ref_cmd; // decoded commands
  logic mclk_q, seen; // last clock, edge seen
  logic [3:0] half_cnt; // cycles since clock edge
  assign cmd = {mem_chip_select_out_n, row_strobe_out_n,
    column_strobe_out_n, write_enable_out_n};
  assign pre_all = cmd == 4'h2 && mem_addr_out[10];
  assign ref_cmd = cmd == 4'h1 && clock_enable_out;
  // ============================================================
  // memory clock half-period counter
  always_ff @(posedge clk_sys or negedge rstn)
    if (!rstn)
    begin
      mclk_q <= 1'b0;
      seen <= 1'b0;
      half_cnt <= 4'h0;
    end
    else
    begin
      mclk_q <= mem_clock_out;
      seen <= seen | (mem_clock_out != mclk_q);
      half_cnt <= (mem_clock_out != mclk_q) ? 4'h1 : half_cnt + 4'h1;
    end
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  // ============================================================
  // register port and pin timing
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property
    (reg_rd && reg_addr > 4'h4 |=> reg_rdata == 8'h00)
    else $error("unmapped index read not zero");
  a_pins_at_step: assert property
    ($changed({cmd, clock_enable_out, mem_addr_out}) |-> $fell(mem_clock_out))
    else $error("sdram pins moved off a step");
  a_mclk_half: assert property
    (seen && mem_clock_out != mclk_q |-> half_cnt == CLK_HALF)
    else $error("memory clock half period wrong");
  // ============================================================
  // command sequencing
  a_preall_nop: assert property (
    $rose(pre_all) |-> pre_all[*4] ##1 mem_chip_select_out_n)
    else $error("precharge-all not one clock then nop");
  a_preall_hold: assert property ($rose(pre_all) |-> cpu_hold)
    else $error("cpu not held during init");
  a_hold_no_ready: assert property (
    cpu_hold && $past(cpu_hold) |-> !acc_ready)
    else $error("access offered while cpu held");
  a_ref_hold: assert property ($rose(ref_cmd) |-> cpu_hold)
    else $error("cpu not held during refresh");
  a_self_no_access: assert property (!clock_enable_out |-> !acc_ready)
    else $error("access offered in self-refresh");
  c_init: cover property (pre_all);
  c_ref: cover property (ref_cmd);
  c_self: cover property (!clock_enable_out);
endmodule // sdic_ctrl_asserts
`default_nettype wire

/* File: verif/sdic_sdram_model.sv */
// behavioural 16-bit sdram: decodes commands, keeps counts
`default_nettype none
module sdic_sdram_model (
  input wire logic clk_sys, // system clock, for spacing
  input wire logic clk, // sdram clock
  input wire logic cke, // clock enable
  input wire logic cs_n, // chip select
  input wire logic [2:0] rcw_n, // ras cas we
  input wire logic [15:0] a, // address
  output logic [15:0] n_pre, // precharge-all count
  output logic [15:0] n_ref, // refresh count
  output logic [15:0] n_mrs, // mode set count
  output logic [15:0] n_act, // activate count
  output logic [15:0] mrs_a, // address at mode set
  output logic [15:0] act_a, // address at activate
  output logic [15:0] init_refs, // refreshes before mode set
  output logic [15:0] ref_gap, // cycles between refreshes
  output logic in_self, // self-refreshing
  output logic bad // command while self-refreshing
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cyc, last, since; // cycle, last refresh, count
  initial
  begin
    {n_pre, n_ref, n_mrs, n_act, mrs_a, act_a, init_refs} = '0;
    {ref_gap, cyc, last, since, in_self, bad} = '0;
  end
  always @(posedge clk_sys)
    cyc <= cyc + 16'h0001;
  // ============================================================
  // command decode at the rising sdram clock
  always @(posedge clk)
  begin
    if (in_self && cke)
      in_self <= 1'b0;
    if (in_self && !cke && !cs_n)
      bad <= 1'b1;
    if (!cs_n && !cke && rcw_n == 3'h1)
      in_self <= 1'b1;
    if (!cs_n && cke)
      case (rcw_n)
        3'h2:
          if (a[10])
          begin
            n_pre <= n_pre + 16'h0001;
            since <= 16'h0000;
          end
        3'h1:
        begin
          n_ref <= n_ref + 16'h0001;
          since <= since + 16'h0001;
          ref_gap <= cyc - last;
          last <= cyc;
        end
        3'h0:
        begin
          n_mrs <= n_mrs + 16'h0001;
          mrs_a <= a;
          init_refs <= since;
        end
        3'h3:
        begin
          n_act <= n_act + 16'h0001;
          act_a <= a;
        end
        default: ;
      endcase
  end
endmodule // sdic_sdram_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the sdram command controller
`default_nettype none
`include "sdic_regs.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, reg_wr, reg_rd; // clock, reset, strobes
  logic [3:0] reg_addr; // register index
  logic [7:0] reg_wdata, reg_rdata, v, mode; // data
  logic acc_valid, acc_ras_n, acc_cas_n, acc_we_n, ok; // access
  logic [14:0] acc_addr, ra; // access address
  logic [1:0] acc_bank, acc_dqm, rb; // bank and masks
  logic acc_ready, cpu_hold, mclk, cke, cs_n, ras_n, cas_n, we_n;
  logic upper_mask, lower_mask; // sdram byte masks
  logic [15:0] addr, n_pre, n_ref, n_mrs, n_act, mrs_a, act_a, b0, b1;
  logic [15:0] init_refs, ref_gap; // model results
  logic in_self, bad; // model state
  logic [31:0] seed; // random seed
  int mismatches, cmp_count; // tallies
  logic [15:0] ivl [8] = '{16'h002F, 16'h004E, 16'h0061, 16'h007C,
    16'h009C, 16'h00C3, 16'h00F9, 16'h0138}; // refresh states
  sdic_ctrl #(.CLK_HALF(2), .GAP_STEPS(4)) u_sdic_ctrl (
    .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .acc_valid(acc_valid), .acc_ras_n(acc_ras_n),
    .acc_cas_n(acc_cas_n), .acc_we_n(acc_we_n), .acc_addr(acc_addr),
    .acc_bank(acc_bank), .acc_dqm(acc_dqm), .acc_ready(acc_ready),
    .cpu_hold(cpu_hold), .mem_clock_out(mclk), .clock_enable_out(cke),
    .mem_chip_select_out_n(cs_n), .row_strobe_out_n(ras_n),
    .column_strobe_out_n(cas_n), .write_enable_out_n(we_n),
    .upper_byte_mask_out(upper_mask), .lower_byte_mask_out(lower_mask),
    .mem_addr_out(addr));
  sdic_sdram_model u_sdic_sdram_model (.clk_sys(clk_sys), .clk(mclk),
    .cke(cke), .cs_n(cs_n), .rcw_n({ras_n, cas_n, we_n}), .a(addr),
    .n_pre(n_pre), .n_ref(n_ref), .n_mrs(n_mrs), .n_act(n_act),
    .mrs_a(mrs_a), .act_a(act_a), .init_refs(init_refs),
    .ref_gap(ref_gap), .in_self(in_self), .bad(bad));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // ============================================================
  // compare, verdict and bus tasks
  task automatic chk(input string what, input logic [15:0] exp, got);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test();
    if (mismatches == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // poll the command field until it is back to none
  task automatic wait_done();
    v = 8'hFF;
    for (int i = 0; i < 600 && v !== 8'h00; i++)
      rd(`SDIC_OFS_CMD, v);
    if (v !== 8'h00)
    begin
      mismatches++;
      end_of_test();
    end
  endtask
  // hold an activate until the sdram sees it or the bound runs out
  task automatic access(input logic [14:0] a, input logic [1:0] b);
    b1 = n_act;
    @(posedge clk_sys);
    {acc_valid, acc_ras_n, acc_addr, acc_bank} <= {2'b10, a, b};
    acc_dqm <= 2'($random(seed));
    for (int i = 0; i < 80 && n_act == b1; i++)
      @(posedge clk_sys);
    ok = n_act != b1;
    {acc_valid, acc_ras_n} <= 2'b01;
  endtask
  // bank bits land by mux type and density flag
  function automatic logic [15:0] place(input logic [14:0] a,
    input logic [1:0] b, input logic [1:0] mx, input logic sm);
    place = {1'b0, a};
    if (mx == 2'h0 && sm)
      place[11] = b[0];
    else if (mx == 2'h0 || (mx == 2'h1 && sm))
      place[13:12] = b;
    else
      place[14:13] = b;
  endfunction
  // ============================================================
  // main sequence
  initial
  begin
    seed = 32'h9f3241f7;
    {rstn, reg_addr, reg_wdata, reg_wr, reg_rd, acc_valid} = '0;
    {acc_addr, acc_bank, acc_dqm} = '0;
    {acc_ras_n, acc_cas_n, acc_we_n} = 3'b111;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(`SDIC_OFS_RCR, v);
    chk("refresh reg reset", `SDIC_RST_RCR, v);
    wr(4'hF, 8'hA5);
    rd(4'hF, v);
    chk("unmapped read", 8'h00, v);
    mode = 8'($random(seed));
    wr(`SDIC_OFS_MODE, mode);
    b0 = n_pre;
    wr(`SDIC_OFS_CMD, {5'h00, `SDIC_CMD_INIT});
    @(posedge clk_sys);
    #1 chk("hold in init", 1'b1, cpu_hold);
    rd(`SDIC_OFS_CMD, v);
    chk("busy field", `SDIC_CMD_INIT, v);
    wr(`SDIC_OFS_CMD, {5'h00, `SDIC_CMD_MRS});
    wait_done();
    repeat (12) @(posedge clk_sys);
    chk("hold after init", 1'b0, cpu_hold);
    chk("precharge-all", b0 + 16'h1, n_pre);
    chk("init refreshes", 16'h8, init_refs);
    chk("mode sets", 16'h1, n_mrs);
    chk("init mode", mode, mrs_a[7:0]);
    mode = 8'($random(seed));
    wr(`SDIC_OFS_ACR, 8'h0D);
    wr(`SDIC_OFS_MODE, mode);
    wr(`SDIC_OFS_CMD, {5'h00, `SDIC_CMD_MRS});
    wait_done();
    chk("lone mode set", 16'h2, n_mrs);
    chk("lone mode", mode, mrs_a[7:0]);
    for (int s = 0; s < 8; s++)
    begin
      wr(`SDIC_OFS_RCR, {4'h0, 3'(s), 1'b1});
      b1 = n_ref + 16'h2;
      for (int i = 0; i < 1000 && n_ref < b1; i++)
        @(posedge clk_sys);
      chk("refresh count", b1, n_ref);
      if (n_ref < b1)
        end_of_test();
      ok = ref_gap + 16'h4 >= ivl[s] && ref_gap <= ivl[s] + 16'hC;
      chk("refresh gap", 1'b1, ok);
    end
    wr(`SDIC_OFS_CMD, {5'h00, `SDIC_CMD_SRE});
    wait_done();
    chk("self cke", 1'b0, cke);
    chk("self entered", 1'b1, in_self);
    rd(`SDIC_OFS_STAT, v);
    chk("self status", 1'b1, v[1]);
    access(15'($random(seed)), 2'($random(seed)));
    chk("access in self", 1'b0, ok);
    b0 = n_ref;
    wr(`SDIC_OFS_CMD, {5'h00, `SDIC_CMD_SRX});
    wait_done();
    chk("self left", 1'b0, in_self);
    chk("exit refresh", 1'b1, n_ref > b0);
    chk("quiet in self", 1'b0, bad);
    for (int m = 0; m < 6; m++)
    begin
      wr(`SDIC_OFS_ACR, {5'h00, 1'(m), 2'(m / 2)});
      ra = 15'($random(seed)) & 15'h07FF;
      rb = 2'($random(seed));
      access(ra, rb);
      chk("access taken", 1'b1, ok);
      if (!ok)
        end_of_test();
      chk("bank place", place(ra, rb, 2'(m / 2), 1'(m)), act_a);
      chk("byte masks", acc_dqm, {upper_mask, lower_mask});
    end
    end_of_test();
  end
endmodule // testbench
bind sdic_ctrl sdic_ctrl_asserts #(.CLK_HALF(CLK_HALF)) u_sdic_ctrl_asserts (
  .clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .acc_ready(acc_ready), .cpu_hold(cpu_hold),
  .mem_clock_out(mem_clock_out), .clock_enable_out(clock_enable_out),
  .mem_chip_select_out_n(mem_chip_select_out_n),
  .row_strobe_out_n(row_strobe_out_n),
  .column_strobe_out_n(column_strobe_out_n),
  .write_enable_out_n(write_enable_out_n), .mem_addr_out(mem_addr_out));
`default_nettype wire
